// ==== rtl/pfs_occupancy.sv ====
// Entry counter of queue 0 with overflow and underflow detection
module pfs_occupancy #(
	parameter int DEPTH   = pfs_pkg::Q0_DEPTH,
	parameter int UW      = pfs_pkg::LEVEL_W
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Producer and consumer strobes
	input  wire logic          push,
	input  wire logic          pop,
	// Occupancy
	output logic [UW-1:0]      pop_units,
	output logic [UW-1:0]      push_units,
	output logic               empty,
	output logic               full,
	output logic               overflow,
	output logic               underflow
);
	import pfs_pkg::*;

	localparam int             CW      = $clog2(DEPTH + 1);
	localparam logic [CW-1:0]  DEPTH_C = CW'(DEPTH);

	logic [CW-1:0]             count_reg;
	logic                      take_push;
	logic                      take_pop;

	// Full queue still takes a push when a pop frees a slot
	assign empty      = (count_reg == '0);
	assign full       = (count_reg == DEPTH_C);
	assign take_push  = push & (~full | pop);
	assign take_pop   = pop & ~empty;
	assign overflow   = push & full & ~pop;
	assign underflow  = pop & empty;
	assign pop_units  = UW'(count_reg >> UNIT_SHIFT);
	assign push_units = UW'((DEPTH_C - count_reg) >> UNIT_SHIFT);

	// Entry count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else if (take_push & ~take_pop)
			count_reg <= count_reg + CW'(1);
		else if (take_pop & ~take_push)
			count_reg <= count_reg - CW'(1);
	end

endmodule

// ==== rtl/pfs_pkg.sv ====
// Package of constants and carrier types for the packet FIFO status slice
package pfs_pkg;

	// ****************************************************************
	// Register map (byte addresses on APB)
	// ****************************************************************
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] OFS_STATUS    = 12'h00C;
	localparam logic [11:0] OFS_PUSH_CTL  = 12'h010;
	localparam logic [11:0] OFS_POP_CTL   = 12'h014;
	localparam logic [11:0] OFS_COUNTS    = 12'h018;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h040;

	// ****************************************************************
	// Status register: one 8-bit lane per queue
	// ****************************************************************
	localparam int          NUM_QUEUES    = 4;
	localparam int          LANE_W        = 8;
	localparam int          ST_SLEEP_LSB  = 0;
	localparam int          ST_OVER       = 2;
	localparam int          ST_PUSH_THR   = 3;
	localparam int          ST_PUSH_SLP   = 4;
	localparam int          ST_UNDER      = 5;
	localparam int          ST_POP_THR    = 6;
	localparam int          ST_POP_SLP    = 7;
	localparam logic [31:0] STATUS_RESET  = 32'h0B0B0B0B;
	localparam logic [31:0] STICKY_BITS   = 32'hB4B4B4B4;
	localparam logic [31:0] MASK_RESET    = 32'h00000000;

	// ****************************************************************
	// Count register of queue 0
	// ****************************************************************
	localparam int          CNT_POP_LSB   = 0;
	localparam int          CNT_EMPTY_BIT = 15;
	localparam int          CNT_PUSH_LSB  = 16;
	localparam int          CNT_FULL_BIT  = 31;
	localparam logic [31:0] COUNTS_RESET  = 32'h01008000;
	localparam logic [31:0] CTL_RESET     = 32'h00000000;

	// Queue 0 depth in 32-entry units; entries are counted x32
	localparam int          UNIT_SHIFT    = 5;
	localparam int          LEVEL_W       = 9;
	localparam int          Q0_DEPTH      = 8192;

	// ****************************************************************
	// Memory sleep state codes
	// ****************************************************************
	localparam logic [1:0]  SLP_ACTIVE    = 2'h0;
	localparam logic [1:0]  SLP_LIGHT     = 2'h1;
	localparam logic [1:0]  SLP_DEEP      = 2'h2;
	localparam logic [1:0]  SLP_OFF       = 2'h3;

	// Push or pop control word, reserved fields kept zero
	typedef struct packed {
		logic [6:0]         rsv_hi;
		logic [8:0]         level;
		logic [10:0]        rsv_mid;
		logic [2:0]         irq_mask;
		logic               kind;
		logic               allow;
	} pfs_ctl_t;

	// Event and level inputs from the datapath of queues 1 to 3
	typedef struct packed {
		logic               push_overflow;
		logic               push_asleep;
		logic               pop_underflow;
		logic               pop_asleep;
		logic               push_thr;
		logic               pop_thr;
		logic [1:0]         sleep_state;
	} pfs_queue_in_t;

endpackage

// ==== rtl/pfs_status_ctrl.sv ====
// APB status and control slice of a four-queue packet FIFO unit
//
// Register access over APB was decided locally.
module pfs_status_ctrl (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [pfs_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Queue 0 producer and consumer strobes
	input  wire logic                   q0_push_req,
	input  wire logic                   q0_pop_req,
	// Queues 1 to 3 events from their datapaths
	input  wire pfs_pkg::pfs_queue_in_t [3:1] far_queue_events,
	// Interrupt and queue 0 memory state
	output logic                        irq,
	output logic [1:0]                  q0_memory_sleep_state
);
	import pfs_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	pfs_ctl_t                push_ctl_reg;
	pfs_ctl_t                pop_ctl_reg;
	logic [31:0]             mask_reg;
	logic [31:0]             sticky_reg;
	logic [31:0]             sticky_next;
	logic [31:0]             level_reg;
	logic [31:0]             level_next;
	logic [31:0]             counts_reg;
	logic [31:0]             counts_next;
	logic [31:0]             set_vec;
	logic [31:0]             clr_vec;
	logic [31:0]             status_vec;
	logic [31:0]             enable_vec;
	logic [31:0]             rd_mux;
	logic [31:0]             prdata_reg;
	logic                    pready_reg;
	logic                    pslverr_reg;
	logic                    irq_reg;
	logic [1:0]              q0_sleep_reg;
	logic [1:0]              q0_sleep_next;
	logic                    setup;
	logic                    wr_take;
	logic                    hit;
	logic [LEVEL_W-1:0]      q0_pop_units;
	logic [LEVEL_W-1:0]      q0_push_units;
	logic                    q0_empty;
	logic                    q0_full;
	logic                    q0_overflow;
	logic                    q0_underflow;
	logic                    q0_push_thr;
	logic                    q0_pop_thr;

	// ****************************************************************
	// APB slave: one wait-free access, answer prepared in setup
	// ****************************************************************
	assign setup   = psel & ~penable;
	assign wr_take = psel & penable & pwrite & pready_reg;

	// Address decode; unmapped offsets answer with an error
	always_comb
	begin
		hit    = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			OFS_STATUS:   rd_mux = status_vec;
			OFS_PUSH_CTL: rd_mux = push_ctl_reg;
			OFS_POP_CTL:  rd_mux = pop_ctl_reg;
			OFS_COUNTS:   rd_mux = counts_reg;
			OFS_IRQ_MASK: rd_mux = mask_reg;
			default:      hit    = 1'b0;
		endcase
	end

	// Response registers, so every bus output comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~hit;
			if (setup & ~pwrite)
				prdata_reg <= rd_mux;
			else if (setup)
				prdata_reg <= 32'h00000000;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ****************************************************************
	// Control registers of queue 0
	// ****************************************************************
	// Reserved fields are dropped on write so they always read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			push_ctl_reg <= CTL_RESET;
			pop_ctl_reg  <= CTL_RESET;
			mask_reg     <= MASK_RESET;
		end
		else if (wr_take)
		begin
			if (paddr == OFS_PUSH_CTL)
			begin
				push_ctl_reg.allow    <= pwdata[0];
				push_ctl_reg.kind     <= pwdata[1];
				push_ctl_reg.irq_mask <= pwdata[4:2];
				push_ctl_reg.level    <= pwdata[24:16];
			end
			if (paddr == OFS_POP_CTL)
			begin
				pop_ctl_reg.allow     <= pwdata[0];
				pop_ctl_reg.kind      <= pwdata[1];
				pop_ctl_reg.irq_mask  <= pwdata[4:2];
				pop_ctl_reg.level     <= pwdata[24:16];
			end
			if (paddr == OFS_IRQ_MASK)
				mask_reg <= pwdata;
		end
	end

	// ****************************************************************
	// Queue 0 occupancy and memory power state
	// ****************************************************************
	pfs_occupancy #(
		.DEPTH      (Q0_DEPTH),
		.UW         (LEVEL_W)
	) pfs_occupancy_inst (
		.pclk       (pclk),
		.presetn    (presetn),
		.push       (q0_push_req),
		.pop        (q0_pop_req),
		.pop_units  (q0_pop_units),
		.push_units (q0_push_units),
		.empty      (q0_empty),
		.full       (q0_full),
		.overflow   (q0_overflow),
		.underflow  (q0_underflow)
	);

	// Threshold conditions against the x32 levels
	assign q0_push_thr = (q0_push_units > push_ctl_reg.level);
	assign q0_pop_thr  = (q0_pop_units > pop_ctl_reg.level);

	// Memory wakes on any access; it only sleeps when both sides allow
	// it and the queue is idle and empty, so no data is lost
	always_comb
	begin
		q0_sleep_next = q0_sleep_reg;
		if (q0_push_req | q0_pop_req)
			q0_sleep_next = SLP_ACTIVE;
		else if (push_ctl_reg.allow & pop_ctl_reg.allow & q0_empty)
			q0_sleep_next = push_ctl_reg.kind ? SLP_OFF : SLP_DEEP;
	end

	// Sleep state starts in shutdown
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q0_sleep_reg <= SLP_OFF;
		else
			q0_sleep_reg <= q0_sleep_next;
	end

	assign q0_memory_sleep_state = q0_sleep_reg;

	// Count register image
	always_comb
	begin
		counts_next                                 = 32'h00000000;
		counts_next[CNT_POP_LSB +: LEVEL_W]         = q0_pop_units;
		counts_next[CNT_EMPTY_BIT]                  = q0_empty;
		counts_next[CNT_PUSH_LSB +: LEVEL_W]        = q0_push_units;
		counts_next[CNT_FULL_BIT]                   = q0_full;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			counts_reg <= COUNTS_RESET;
		else
			counts_reg <= counts_next;
	end

	// ****************************************************************
	// Per-queue status lanes
	// ****************************************************************
	// Lane 0 from local logic, lanes 1-3 from the far datapaths
	for (genvar i = 0; i < NUM_QUEUES; i++)
	begin : g_lane
		localparam int B = i * LANE_W;
		if (i == 0)
		begin : g_local
			assign set_vec[B +: LANE_W] = {
				q0_pop_req & (q0_sleep_reg != SLP_ACTIVE),
				1'b0,
				q0_underflow,
				q0_push_req & (q0_sleep_reg != SLP_ACTIVE),
				1'b0,
				q0_overflow,
				2'b00};
			assign level_next[B +: LANE_W] = {
				1'b0, q0_pop_thr, 2'b00, q0_push_thr, 1'b0,
				q0_sleep_reg};
			assign enable_vec[B +: LANE_W] = mask_reg[B +: LANE_W] &
				{pop_ctl_reg.irq_mask, push_ctl_reg.irq_mask, 2'b00};
		end
		else
		begin : g_far
			assign set_vec[B +: LANE_W] = {
				far_queue_events[i].pop_asleep,
				1'b0,
				far_queue_events[i].pop_underflow,
				far_queue_events[i].push_asleep,
				1'b0,
				far_queue_events[i].push_overflow,
				2'b00};
			assign level_next[B +: LANE_W] = {
				1'b0, far_queue_events[i].pop_thr, 2'b00,
				far_queue_events[i].push_thr, 1'b0,
				far_queue_events[i].sleep_state};
			assign enable_vec[B +: LANE_W] =
				mask_reg[B +: LANE_W] & 8'hFC;
		end
	end

	// Write-one clears only the sticky bits; threshold bits ignore it
	assign clr_vec = (wr_take && paddr == OFS_STATUS) ?
		(pwdata & STICKY_BITS) : 32'h00000000;
	// A flag set in the same cycle as its clear survives
	assign sticky_next = ((sticky_reg & ~clr_vec) | set_vec) & STICKY_BITS;
	assign status_vec  = sticky_reg | level_reg;

	// Sticky event flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sticky_reg <= 32'h00000000;
		else
			sticky_reg <= sticky_next;
	end

	// Level bits: sleep states and threshold flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_reg <= STATUS_RESET;
		else
			level_reg <= level_next;
	end

	// Level interrupt, high while any unmasked status bit outside the two sleep-state bits of each lane is set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_vec & enable_vec);
	end

	assign irq = irq_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_q0_wake;
		q0_push_req | q0_pop_req;
	endsequence

	sequence s_q0_sleepy;
		!q0_push_req && !q0_pop_req && push_ctl_reg.allow &&
			pop_ctl_reg.allow && q0_empty;
	endsequence

	property p_over_sticky;
		q0_overflow |=> sticky_reg[ST_OVER] ##1
			(sticky_reg[ST_OVER] || $past(clr_vec[ST_OVER]));
	endproperty
	a_over_sticky: assert property (p_over_sticky)
		else $error("overflow flag not held");

	property p_w1c;
		(wr_take && paddr == OFS_STATUS && pwdata[ST_UNDER] &&
			!q0_underflow) |=> !sticky_reg[ST_UNDER];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("underflow flag not cleared by write one");

	property p_push_thr;
		(q0_push_units > push_ctl_reg.level) |=> level_reg[ST_PUSH_THR];
	endproperty
	a_push_thr: assert property (p_push_thr)
		else $error("push threshold flag wrong");

	property p_pop_thr;
		(q0_pop_units <= pop_ctl_reg.level) |=> !level_reg[ST_POP_THR];
	endproperty
	a_pop_thr: assert property (p_pop_thr)
		else $error("pop threshold flag wrong");

	property p_push_mask;
		(wr_take && paddr == OFS_PUSH_CTL) |=>
			push_ctl_reg.irq_mask == $past(pwdata[4:2]) &&
			push_ctl_reg.level == $past(pwdata[24:16]);
	endproperty
	a_push_mask: assert property (p_push_mask)
		else $error("push control not stored");

	property p_pop_mask_off;
		(pop_ctl_reg.irq_mask == 3'b000 && mask_reg == 32'h000000E0)
			|=> !irq;
	endproperty
	a_pop_mask_off: assert property (p_pop_mask_off)
		else $error("masked pop source raised interrupt");

	property p_sleep_entry;
		s_q0_sleepy ##1 s_q0_sleepy |=>
			q0_sleep_reg ==
			($past(push_ctl_reg.kind) ? SLP_OFF : SLP_DEEP);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("queue 0 memory did not sleep");

	property p_pop_count;
		##1 counts_reg[CNT_POP_LSB +: LEVEL_W] == $past(q0_pop_units);
	endproperty
	a_pop_count: assert property (p_pop_count)
		else $error("pop count field stale");

	property p_push_count;
		q0_push_req && !q0_pop_req && !q0_full |=> ##1
			counts_reg[CNT_PUSH_LSB +: LEVEL_W] <= $past(q0_push_units, 2);
	endproperty
	a_push_count: assert property (p_push_count)
		else $error("push count field grew on push");

	property p_wake;
		s_q0_wake |=> q0_sleep_reg == SLP_ACTIVE;
	endproperty
	a_wake: assert property (p_wake)
		else $error("memory not active after access");

endmodule

// ==== tb/pfs_far_side.sv ====
// Far-side model: queue 0 producer and consumer, queue 1-3 datapaths
module pfs_far_side (
	// Clock
	input  wire logic                    pclk,
	// Queue 0 strobes
	output logic                         q0_push_req,
	output logic                         q0_pop_req,
	// Queue 1 to 3 events and levels
	output pfs_pkg::pfs_queue_in_t [3:1] far_queue_events
);
	timeunit 1ns;
	timeprecision 1ns;
	import pfs_pkg::*;

	// ****************************************************************
	// Idle state: memories off, push level met, pop level not met
	// ****************************************************************
	initial
	begin
		q0_push_req = 1'b0;
		q0_pop_req = 1'b0;
		for (int q = 1; q <= 3; q++)
			far_queue_events[q] = '{push_thr: 1'b1, sleep_state: SLP_OFF,
				default: 1'b0};
	end

	// Push or pop n entries; slow leaves a gap so the design sees stalls
	task automatic xfer(input logic is_pop, input int n, input logic slow);
		repeat (n)
		begin
			q0_pop_req  <= is_pop;
			q0_push_req <= !is_pop;
			@(posedge pclk);
			if (slow)
			begin
				q0_pop_req  <= 1'b0;
				q0_push_req <= 1'b0;
				@(posedge pclk);
			end
		end
		q0_pop_req  <= 1'b0;
		q0_push_req <= 1'b0;
		@(posedge pclk);
	endtask

	// One-cycle event on queue q: 0 over, 1 push asleep, 2 under, 3 pop asleep
	task automatic pulse(input int q, input int k);
		far_queue_events[q].push_overflow <= (k == 0);
		far_queue_events[q].push_asleep   <= (k == 1);
		far_queue_events[q].pop_underflow <= (k == 2);
		far_queue_events[q].pop_asleep    <= (k == 3);
		@(posedge pclk);
		far_queue_events[q].push_overflow <= 1'b0;
		far_queue_events[q].push_asleep   <= 1'b0;
		far_queue_events[q].pop_underflow <= 1'b0;
		far_queue_events[q].pop_asleep    <= 1'b0;
		@(posedge pclk);
	endtask

	// Level inputs of queue q
	task automatic levels(input int q, input logic [1:0] s, input logic pu,
		input logic po);
		far_queue_events[q].sleep_state <= s;
		far_queue_events[q].push_thr    <= pu;
		far_queue_events[q].pop_thr     <= po;
		@(posedge pclk);
	endtask
endmodule

// ==== tb/pfs_status_ctrl_test.sv ====
// Self-checking bench of the packet FIFO status and control slice
module pfs_status_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pfs_pkg::*;

	// ****************************************************************
	// Signals and bookkeeping
	// ****************************************************************
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                q0_push_req;
	logic                q0_pop_req;
	pfs_queue_in_t [3:1] far_queue_events;
	logic                irq;
	logic [1:0]          q0_memory_sleep_state;
	logic [31:0]         rd_data;
	logic                rd_err;
	int                  fail_count;
	int                  check_count;
	int                  kb[4] = '{ST_OVER, ST_PUSH_SLP, ST_UNDER, ST_POP_SLP};

	pfs_status_ctrl pfs_status_ctrl_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .q0_push_req(q0_push_req),
		.q0_pop_req(q0_pop_req), .far_queue_events(far_queue_events),
		.irq(irq), .q0_memory_sleep_state(q0_memory_sleep_state));

	pfs_far_side pfs_far_side_inst (.pclk(pclk),
		.q0_push_req(q0_push_req), .q0_pop_req(q0_pop_req),
		.far_queue_events(far_queue_events));

	// 100 ns period
	always #50 pclk = ~pclk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is sampled; no wait count is assumed
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_data & m, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Sleep entry latency is not fixed, so poll a bounded while
	task automatic wait_sleep(input logic [1:0] s);
		for (int n = 0; n < 20 && q0_memory_sleep_state !== s; n++)
			@(posedge pclk);
		chk({30'h0, q0_memory_sleep_state}, {30'h0, s});
	endtask

	task automatic close_out();
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk({30'h0, q0_memory_sleep_state}, {30'h0, SLP_OFF});
		rd_chk(OFS_STATUS, '1, STATUS_RESET);
		rd_chk(OFS_COUNTS, '1, COUNTS_RESET);
		rd_chk(OFS_PUSH_CTL, '1, CTL_RESET);
		rd_chk(OFS_POP_CTL, '1, CTL_RESET);
		rd_chk(OFS_IRQ_MASK, '1, MASK_RESET);
	endtask

	// Reserved bits must read zero; counts ignore writes
	task automatic t_ctl();
		wr(OFS_PUSH_CTL, 32'hFFFFFFFF);
		rd_chk(OFS_PUSH_CTL, '1, 32'h01FF001F);
		wr(OFS_POP_CTL, 32'hFFFFFFFF);
		rd_chk(OFS_POP_CTL, '1, 32'h01FF001F);
		wr(OFS_PUSH_CTL, 32'h0);
		wr(OFS_POP_CTL, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({rd_data[30:0], rd_err}, 32'h1);
		wr(OFS_COUNTS, 32'h0);
		rd_chk(OFS_COUNTS, '1, COUNTS_RESET);
	endtask

	task automatic t_far();
		int b;
		for (int q = 1; q <= 3; q++)
			for (int k = 0; k < 4; k++)
			begin
				b = LANE_W * q + kb[k];
				pfs_far_side_inst.pulse(q, k);
				rd_chk(OFS_STATUS, 32'h1 << b, 32'h1 << b);
				wr(OFS_STATUS, 32'h1 << b);
				rd_chk(OFS_STATUS, 32'h1 << b, 32'h0);
			end
		pfs_far_side_inst.levels(1, SLP_OFF, 1'b0, 1'b0);
		pfs_far_side_inst.levels(2, SLP_LIGHT, 1'b1, 1'b0);
		pfs_far_side_inst.levels(3, SLP_OFF, 1'b1, 1'b1);
		wr(OFS_STATUS, 32'hFFFFFFFF);
		rd_chk(OFS_STATUS, 32'hFFFFFF00, 32'h4B090300);
		for (int q = 1; q <= 3; q++)
			pfs_far_side_inst.levels(q, SLP_OFF, 1'b1, 1'b0);
		pfs_far_side_inst.pulse(1, 0);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h400);
		idle(2);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_STATUS, 32'h400);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0);
	endtask

	// Thresholds are strict: a level equal to the count clears the flag
	task automatic t_q0();
		pfs_far_side_inst.xfer(1'b0, 64, 1'b0);
		idle(3);
		rd_chk(OFS_COUNTS, '1, 32'h00FE0002);
		rd_chk(OFS_STATUS, 32'h48, 32'h48);
		wr(OFS_POP_CTL, 32'h00020000);
		wr(OFS_PUSH_CTL, 32'h00FE0000);
		idle(3);
		rd_chk(OFS_STATUS, 32'h48, 32'h0);
		wr(OFS_PUSH_CTL, 32'h00FD0000);
		idle(3);
		rd_chk(OFS_STATUS, 32'h48, 32'h08);
		pfs_far_side_inst.xfer(1'b0, Q0_DEPTH - 64, 1'b0);
		pfs_far_side_inst.xfer(1'b0, 1, 1'b0);
		idle(3);
		rd_chk(OFS_COUNTS, '1, 32'h80000100);
		rd_chk(OFS_STATUS, 32'h4, 32'h4);
		wr(OFS_PUSH_CTL, 32'h4);
		wr(OFS_IRQ_MASK, 32'h4);
		idle(2);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_PUSH_CTL, 32'h0);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0);
		pfs_far_side_inst.xfer(1'b1, Q0_DEPTH, 1'b1);
		pfs_far_side_inst.xfer(1'b1, 1, 1'b0);
		idle(3);
		rd_chk(OFS_COUNTS, '1, COUNTS_RESET);
		rd_chk(OFS_STATUS, 32'h20, 32'h20);
		wr(OFS_IRQ_MASK, 32'hE0);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_POP_CTL, 32'h4);
		idle(2);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_POP_CTL, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0);
	endtask

	// Accesses while asleep flag and wake the memory
	task automatic t_sleep();
		wr(OFS_STATUS, 32'hFF);
		wr(OFS_POP_CTL, 32'h1);
		wr(OFS_PUSH_CTL, 32'h3);
		wait_sleep(SLP_OFF);
		wr(OFS_PUSH_CTL, 32'h1);
		wait_sleep(SLP_DEEP);
		pfs_far_side_inst.xfer(1'b1, 1, 1'b0);
		wait_sleep(SLP_DEEP);
		pfs_far_side_inst.xfer(1'b0, 1, 1'b0);
		wait_sleep(SLP_ACTIVE);
		rd_chk(OFS_STATUS, 32'hB7, 32'hB0);
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		fail_count = 0;
		check_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_ctl();
		t_far();
		t_q0();
		t_sleep();
		close_out();
	end

	// Whole run needs about 25000 cycles
	initial
	begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		close_out();
	end
endmodule
